// ---- dkua_pkg.sv ----
package dkua_pkg;

    // register bus geometry
    localparam int unsigned AXI_ADDR_W      = 8;
    localparam int unsigned AXI_DATA_W      = 32;
    localparam int unsigned REG_IDX_W       = 6;

    // register indices; byte address is four times the index
    localparam logic [5:0]  IDX_KEY_STATUS  = 6'h07;
    localparam logic [5:0]  IDX_RESET_REQ   = 6'h08;
    localparam logic [5:0]  IDX_SYS_CTRL    = 6'h0a;
    localparam logic [5:0]  IDX_SYS_STATUS  = 6'h0b;

    // key status fields
    localparam int unsigned KEY_UROW_BIT    = 5;
    localparam int unsigned KEY_PROG_BIT    = 4;
    localparam int unsigned KEY_ERASE_BIT   = 3;

    // system control fields
    localparam int unsigned CTRL_COMMIT_BIT = 1;
    localparam int unsigned CTRL_KEEP_CLOCK_REQUEST_BIT = 0;
    localparam logic        KEEP_CLOCK_REQUEST_RESET    = 1'b1;

    // system status fields
    localparam int unsigned ST_RSTSYS_BIT   = 5;
    localparam int unsigned ST_SLEEP_BIT    = 4;
    localparam int unsigned ST_PROG_BIT     = 3;
    localparam int unsigned ST_UROW_BIT     = 2;
    localparam int unsigned ST_LOCK_BIT     = 0;

    // key signatures, least significant byte arrives first
    localparam logic [63:0] KEY_SIG_ERASE   = 64'h4e564d4572617365;
    localparam logic [63:0] KEY_SIG_PROG    = 64'h4e564d50726f6720;
    localparam logic [63:0] KEY_SIG_UROW    = 64'h4e564d5573267465;
    localparam logic [3:0]  KEY_LAST_BYTE   = 4'h7;

    // reset request values
    localparam logic [7:0]  RESET_SIG       = 8'ha5;
    localparam logic [7:0]  RESET_RELEASE   = 8'h00;

    // sleep mode encoding from the system domain
    localparam logic [1:0]  SLEEP_NONE      = 2'h0;

    // user row size in bytes
    localparam int unsigned UROW_BYTES      = 32;

    // axi responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } dkua_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } dkua_axi_rsp_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } dkua_byte_write_type;

    typedef struct packed {
        dkua_axi_rsp_type axi;
        logic             aw_held;
        logic [7:0]       aw_addr;
        logic             w_held;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic [63:0]      key_shift;
        logic [3:0]       key_count;
        logic             erase_key;
        logic             prog_key;
        logic             urow_key;
        logic [7:0]       reset_req;
        logic             sys_reset;
        logic             erase_busy;
        logic             erase_start;
        logic             prog_enabled;
        logic             urow_active;
        logic             commit;
        logic             keep_clock;
        logic             bod_force;
        logic [2:0]       bod_level;
        logic             bus_grant;
        logic             sram_read_ok;
        logic             phy_clock_on;
        logic             sleeping;
        logic             sync_event;
    } dkua_top_state_type;

endpackage : dkua_pkg

// ---- dkua_user_row_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none

module dkua_user_row_buffer #(
    parameter int unsigned ROW_BYTES = dkua_pkg::UROW_BYTES
) (
    // clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          resetn_in,
    // control
    input  wire logic                          active_in,
    input  wire logic                          commit_in,
    input  wire dkua_pkg::dkua_byte_write_type wr_in,
    // copy port toward the user row
    output logic                               row_valid_out,
    output logic [$clog2(ROW_BYTES)-1:0]       row_addr_out,
    output logic [7:0]                         row_data_out,
    input  wire logic                          row_ready_in,
    // status
    output logic                               busy_out,
    output logic                               done_out
);

    localparam int unsigned AW = $clog2(ROW_BYTES);

    typedef struct packed {
        logic [ROW_BYTES-1:0][7:0] mem;
        logic                      copying;
        logic                      valid;
        logic [AW-1:0]             addr;
        logic [7:0]                data;
        logic                      done;
    } dkua_row_state_type;

    dkua_row_state_type s;
    dkua_row_state_type next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        // out-of-range writes simply fall away
        if (active_in && wr_in.valid && !s.copying && wr_in.addr < 16'(ROW_BYTES)) begin
            next_s.mem[wr_in.addr[AW-1:0]] = wr_in.data;
        end
        if (commit_in && active_in && !s.copying) begin
            next_s.copying = 1'b1;
            next_s.valid   = 1'b1;
            next_s.addr    = '0;
            next_s.data    = s.mem[0];
        end else if (s.copying && s.valid && row_ready_in) begin
            if (s.addr == AW'(ROW_BYTES - 1)) begin
                next_s.copying = 1'b0;
                next_s.valid   = 1'b0;
                next_s.done    = 1'b1;
            end else begin
                next_s.addr = AW'(s.addr + 1'b1);
                next_s.data = s.mem[AW'(s.addr + 1'b1)];
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign row_valid_out = s.valid;
    assign row_addr_out  = s.addr;
    assign row_data_out  = s.data;
    assign busy_out      = s.copying;
    assign done_out      = s.done;

endmodule : dkua_user_row_buffer

`default_nettype wire

// ---- dkua_access.sv ----
`timescale 1ns/1ps
`default_nettype none

// Contract
// - 64-bit keys only; no reply.
// - match erase, program, user-row keys, low byte first.
// - program enable needs lock clear; status flag.
// - user-row key works on locked part; status flag.
// - erase key keeps active program key.
// - active keys read back in key status.
// - reset signature asserts reset; zero releases.
// - lock flag reads one until erase done.
// - finished erase clears lock, grants bus.
// - locked part blocks system bus.
// - erase forces brown-out on at fuse level.
// - program flag one after key and reset pulse.
// - user-row flag one after key and reset pulse.
// - user-row mode keeps byte writes to addresses below 32 only.
// - buffered bytes copied one to one.
// - commit starts copy; flag clears when done.
// - writing user-row key flag clears that key.
// - user-row mode refuses sram reads.
// - each sync rising edge emits an event.
// - link clock runs in sleep while enabled.
// - stopped cpu clock blocks bus reads when keep-clock is clear.
// - sleeping flag set for idle or deeper.
// - keep-clock request keeps bus access.
// - keep-clock request resets to one.
module dkua_access (
    // clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          resetn_in,
    // register bus
    input  wire dkua_pkg::dkua_axi_req_type    axi_req_in,
    output dkua_pkg::dkua_axi_rsp_type         axi_rsp_out,
    // link layer
    input  wire logic                          link_enable_in,
    input  wire logic                          key_frame_start_in,
    input  wire logic                          key_byte_valid_in,
    input  wire logic [7:0]                    key_byte_in,
    input  wire logic                          sync_rise_in,
    input  wire dkua_pkg::dkua_byte_write_type mem_wr_in,
    output logic                               sync_event_out,
    output logic                               phy_clock_on_out,
    // system domain
    input  wire logic                          lock_bits_in,
    input  wire logic                          erase_done_in,
    input  wire logic [1:0]                    sleep_mode_in,
    input  wire logic                          cpu_clock_stopped_in,
    input  wire logic [2:0]                    bod_fuse_level_in,
    output logic                               sys_reset_out,
    output logic                               erase_start_out,
    output logic                               bod_force_active_out,
    output logic [2:0]                         bod_level_out,
    output logic                               keep_clock_out,
    output logic                               bus_grant_out,
    output logic                               sram_read_ok_out,
    output logic                               prog_enabled_out,
    // user row copy port
    output logic                               row_valid_out,
    output logic [4:0]                         row_addr_out,
    output logic [7:0]                         row_data_out,
    input  wire logic                          row_ready_in
);

    dkua_pkg::dkua_top_state_type s;
    dkua_pkg::dkua_top_state_type next_s;

    logic       row_busy;
    logic       row_done;
    logic       locked;
    logic [7:0] rd_byte;
    logic       rd_hit;
    logic [5:0] rd_idx;
    logic [5:0] wr_idx;
    logic       wr_hit;
    logic [63:0] key_full;

    dkua_user_row_buffer #(
        .ROW_BYTES (dkua_pkg::UROW_BYTES)
    ) u_row (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .active_in     (s.urow_active),
        .commit_in     (s.commit),
        .wr_in         (mem_wr_in),
        .row_valid_out (row_valid_out),
        .row_addr_out  (row_addr_out),
        .row_data_out  (row_data_out),
        .row_ready_in  (row_ready_in),
        .busy_out      (row_busy),
        .done_out      (row_done)
    );

    // lock reads high while erase runs
    assign locked   = lock_bits_in | s.erase_busy;
    assign rd_idx   = axi_req_in.araddr[7:2];
    assign wr_idx   = s.aw_addr[7:2];
    assign key_full = {key_byte_in, s.key_shift[63:8]};

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        unique case (rd_idx)
            dkua_pkg::IDX_KEY_STATUS: begin
                rd_byte[dkua_pkg::KEY_UROW_BIT]  = s.urow_key;
                rd_byte[dkua_pkg::KEY_PROG_BIT]  = s.prog_key;
                rd_byte[dkua_pkg::KEY_ERASE_BIT] = s.erase_key;
            end
            dkua_pkg::IDX_RESET_REQ: begin
                rd_byte = s.reset_req;
            end
            dkua_pkg::IDX_SYS_CTRL: begin
                rd_byte[dkua_pkg::CTRL_KEEP_CLOCK_REQUEST_BIT] = s.keep_clock;
            end
            dkua_pkg::IDX_SYS_STATUS: begin
                rd_byte[dkua_pkg::ST_RSTSYS_BIT] = s.sys_reset;
                rd_byte[dkua_pkg::ST_SLEEP_BIT]  = s.sleeping;
                rd_byte[dkua_pkg::ST_PROG_BIT]   = s.prog_enabled;
                rd_byte[dkua_pkg::ST_UROW_BIT]   = s.urow_active;
                rd_byte[dkua_pkg::ST_LOCK_BIT]   = locked;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign wr_hit = (wr_idx == dkua_pkg::IDX_KEY_STATUS) || (wr_idx == dkua_pkg::IDX_RESET_REQ)
                 || (wr_idx == dkua_pkg::IDX_SYS_CTRL) || (wr_idx == dkua_pkg::IDX_SYS_STATUS);

    always_comb begin
        next_s = s;
        next_s.erase_start = 1'b0;
        next_s.commit      = 1'b0;

        // bus: accept address and data in either order
        if (axi_req_in.awvalid && s.axi.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && s.axi.wready) begin
            next_s.w_held = 1'b1;
            next_s.w_data = axi_req_in.wdata;
            next_s.w_strb = axi_req_in.wstrb;
        end
        if (s.axi.bvalid && axi_req_in.bready) begin
            next_s.axi.bvalid = 1'b0;
        end
        if (s.axi.rvalid && axi_req_in.rready) begin
            next_s.axi.rvalid = 1'b0;
        end
        if (axi_req_in.arvalid && s.axi.arready) begin
            next_s.axi.rvalid = 1'b1;
            next_s.axi.rdata  = {24'h000000, rd_byte};
            next_s.axi.rresp  = rd_hit ? dkua_pkg::RESP_OKAY : dkua_pkg::RESP_SLVERR;
        end

        // key reception; no reply is ever produced
        if (key_frame_start_in) begin
            next_s.key_count = 4'h0;
        end else if (key_byte_valid_in) begin
            next_s.key_shift = key_full;
            if (s.key_count == dkua_pkg::KEY_LAST_BYTE) begin
                next_s.key_count = 4'h0;
                if (key_full == dkua_pkg::KEY_SIG_ERASE) begin
                    next_s.erase_key = 1'b1;
                end else if (key_full == dkua_pkg::KEY_SIG_PROG) begin
                    next_s.prog_key = 1'b1;
                end else if (key_full == dkua_pkg::KEY_SIG_UROW) begin
                    next_s.urow_key = 1'b1;
                end
            end else begin
                next_s.key_count = 4'(s.key_count + 1'b1);
            end
        end

        // register write, once address and data are both in
        if (s.aw_held && s.w_held && !s.axi.bvalid) begin
            next_s.aw_held    = 1'b0;
            next_s.w_held     = 1'b0;
            next_s.axi.bvalid = 1'b1;
            next_s.axi.bresp  = wr_hit ? dkua_pkg::RESP_OKAY : dkua_pkg::RESP_SLVERR;
            if (s.w_strb[0]) begin
                unique case (wr_idx)
                    dkua_pkg::IDX_KEY_STATUS: begin
                        if (s.w_data[dkua_pkg::KEY_UROW_BIT]) begin
                            next_s.urow_key = 1'b0;
                        end
                    end
                    dkua_pkg::IDX_RESET_REQ: begin
                        next_s.reset_req = s.w_data[7:0];
                        if (s.w_data[7:0] == dkua_pkg::RESET_SIG) begin
                            next_s.sys_reset = 1'b1;
                            if (s.prog_enabled) begin
                                // second reset pulse closes programming
                                next_s.prog_enabled = 1'b0;
                                next_s.prog_key     = 1'b0;
                            end
                        end else if (s.w_data[7:0] == dkua_pkg::RESET_RELEASE) begin
                            next_s.sys_reset = 1'b0;
                            if (s.sys_reset) begin
                                if (s.erase_key && !s.erase_busy) begin
                                    next_s.erase_busy  = 1'b1;
                                    next_s.erase_start = 1'b1;
                                end
                                if (s.prog_key && !locked && !s.erase_key) begin
                                    next_s.prog_enabled = 1'b1;
                                end
                                if (s.urow_key && locked && !s.prog_enabled) begin
                                    next_s.urow_active = 1'b1;
                                end
                            end
                        end
                    end
                    dkua_pkg::IDX_SYS_CTRL: begin
                        next_s.keep_clock = s.w_data[dkua_pkg::CTRL_KEEP_CLOCK_REQUEST_BIT];
                        if (s.w_data[dkua_pkg::CTRL_COMMIT_BIT] && s.urow_active && !row_busy) begin
                            next_s.commit = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // erase progress
        if (s.erase_busy && erase_done_in) begin
            next_s.erase_busy = 1'b0;
            next_s.erase_key  = 1'b0;
        end
        next_s.bod_force = next_s.erase_busy;
        next_s.bod_level = next_s.erase_busy ? bod_fuse_level_in : 3'h0;

        // flag held until copy ends
        if (row_done) begin
            next_s.urow_active = 1'b0;
        end

        // link off drops keys and modes
        if (!link_enable_in) begin
            next_s.erase_key    = 1'b0;
            next_s.prog_key     = 1'b0;
            next_s.urow_key     = 1'b0;
            next_s.prog_enabled = 1'b0;
            next_s.urow_active  = 1'b0;
        end

        // access gating
        next_s.bus_grant    = !locked && !(cpu_clock_stopped_in && !s.keep_clock);
        next_s.sram_read_ok = next_s.bus_grant && !s.urow_active;
        next_s.sleeping     = (sleep_mode_in != dkua_pkg::SLEEP_NONE);
        next_s.phy_clock_on = link_enable_in;
        next_s.sync_event   = sync_rise_in;

        next_s.axi.awready = !next_s.aw_held && !next_s.axi.bvalid;
        next_s.axi.wready  = !next_s.w_held && !next_s.axi.bvalid;
        next_s.axi.arready = !next_s.axi.rvalid;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s            <= '0;
            s.keep_clock <= dkua_pkg::KEEP_CLOCK_REQUEST_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign axi_rsp_out          = s.axi;
    assign sync_event_out       = s.sync_event;
    assign phy_clock_on_out     = s.phy_clock_on;
    assign sys_reset_out        = s.sys_reset;
    assign erase_start_out      = s.erase_start;
    assign bod_force_active_out = s.bod_force;
    assign bod_level_out        = s.bod_level;
    assign keep_clock_out       = s.keep_clock;
    assign bus_grant_out        = s.bus_grant;
    assign sram_read_ok_out     = s.sram_read_ok;
    assign prog_enabled_out     = s.prog_enabled;

endmodule : dkua_access

`default_nettype wire

// ---- dkua_access_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dkua_access_sva (
    // clock and reset
    input wire logic                       clk_in,
    input wire logic                       resetn_in,
    // register bus
    input wire dkua_pkg::dkua_axi_req_type axi_req_in,
    input wire dkua_pkg::dkua_axi_rsp_type axi_rsp_out,
    // link and system
    input wire logic                       link_enable_in,
    input wire logic                       sync_rise_in,
    input wire logic                       sync_event_out,
    input wire logic                       phy_clock_on_out,
    input wire logic                       lock_bits_in,
    input wire logic                       erase_done_in,
    input wire logic                       cpu_clock_stopped_in,
    input wire logic [2:0]                 bod_fuse_level_in,
    input wire logic                       bod_force_active_out,
    input wire logic [2:0]                 bod_level_out,
    input wire logic                       keep_clock_out,
    input wire logic                       bus_grant_out,
    // user row copy
    input wire logic                       row_valid_out,
    input wire logic [4:0]                 row_addr_out,
    input wire logic [7:0]                 row_data_out,
    input wire logic                       row_ready_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence aw_w_taken;
        axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid && axi_rsp_out.wready;
    endsequence
    sequence row_stalled;
        row_valid_out && !row_ready_in;
    endsequence
    chk_write_answer: assert property (aw_w_taken |-> ##2 axi_rsp_out.bvalid)
        else $error("write answer late");
    chk_read_answer: assert property (axi_req_in.arvalid && axi_rsp_out.arready |=> axi_rsp_out.rvalid)
        else $error("read answer late");
    chk_sync_event: assert property (sync_rise_in |=> sync_event_out)
        else $error("no sync event");
    chk_phy_clock: assert property (link_enable_in |=> phy_clock_on_out)
        else $error("link clock stopped");
    chk_lock_block: assert property (lock_bits_in |=> !bus_grant_out)
        else $error("bus granted while locked");
    chk_cpu_stop: assert property (cpu_clock_stopped_in && !keep_clock_out |=> !bus_grant_out)
        else $error("granted, cpu off");
    chk_keep_grant: assert property (!lock_bits_in && !bod_force_active_out && keep_clock_out
        |=> bus_grant_out)
        else $error("bus refused");
    chk_bod_level: assert property (bod_level_out == (bod_force_active_out ? bod_fuse_level_in
        : 3'h0))
        else $error("brownout level wrong");
    chk_erase_end: assert property (erase_done_in && bod_force_active_out
        |=> !bod_force_active_out)
        else $error("erase did not end");
    chk_row_hold: assert property (row_stalled |=> row_valid_out && $stable(row_addr_out)
        && $stable(row_data_out))
        else $error("row copy unstable");
endmodule : dkua_access_sva
bind dkua_access dkua_access_sva chk_u (.*);
`default_nettype wire

// ---- dkua_debugger_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dkua_debugger_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // command from the bench
    input  wire logic        go_in,
    input  wire logic [63:0] key_in,
    // key bytes toward the device
    output logic             frame_start_out,
    output logic             byte_valid_out,
    output logic [7:0]       byte_out,
    output logic             busy_out
);
    logic [63:0] shift;
    logic [3:0]  left;
    assign busy_out = go_in || (left != 4'h0) || byte_valid_out;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {shift, left, frame_start_out, byte_valid_out, byte_out} <= '0;
        end else if (go_in) begin
            // eight bytes, no answer awaited
            {shift, left, frame_start_out, byte_valid_out} <= {key_in, 4'h8, 2'b10};
        end else if (left != 4'h0) begin
            {shift, left} <= {8'h00, shift[63:8], left - 4'h1};
            {frame_start_out, byte_valid_out, byte_out} <= {2'b01, shift[7:0]};
        end else begin
            {frame_start_out, byte_valid_out} <= 2'b00;
            // released line keeps changing
            byte_out <= ~byte_out;
        end
    end
endmodule : dkua_debugger_model
`default_nettype wire

// ---- debug_key_unlock_access_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module debug_key_unlock_access_bench;
    localparam logic [71:0] KEY_ROWS [4] = '{{dkua_pkg::KEY_SIG_ERASE, 8'h08},
        {dkua_pkg::KEY_SIG_PROG, 8'h10}, {dkua_pkg::KEY_SIG_UROW, 8'h20},
        {64'h0123456789abcdef, 8'h00}};
    logic clk_in = 1'b0, resetn_in = 1'b0, link_enable_in = 1'b1, lock_bits_in = 1'b1;
    logic sync_rise_in = 1'b0, erase_done_in = 1'b0, cpu_clock_stopped_in = 1'b0;
    logic row_ready_in = 1'b0, dbg_go = 1'b0, key_frame_start_in, key_byte_valid_in, dbg_busy;
    logic sync_event_out, phy_clock_on_out, sys_reset_out, erase_start_out, bod_force_active_out;
    logic keep_clock_out, bus_grant_out, sram_read_ok_out, prog_enabled_out, row_valid_out;
    logic [1:0] sleep_mode_in = 2'h0, rr;
    logic [2:0] bod_fuse_level_in = 3'h5, bod_level_out;
    logic [4:0] row_addr_out;
    logic [7:0] key_byte_in, row_data_out;
    logic [31:0] rd;
    logic [63:0] dbg_key = 64'h0;
    dkua_pkg::dkua_axi_req_type axi_req_in = '0;
    dkua_pkg::dkua_axi_rsp_type axi_rsp_out;
    dkua_pkg::dkua_byte_write_type mem_wr_in = '0;
    int miscompares = 0, compares = 0, n;
    dkua_access dut_u (.*);
    dkua_debugger_model dbg_u (.clk_in(clk_in), .resetn_in(resetn_in), .go_in(dbg_go),
        .key_in(dbg_key), .frame_start_out(key_frame_start_in),
        .byte_valid_out(key_byte_valid_in), .byte_out(key_byte_in), .busy_out(dbg_busy));
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic test_done;
        if (miscompares == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic stuck;
        miscompares++;
        test_done();
    endtask : stuck
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        axi_req_in <= '{awaddr: a, awvalid: 1'b1, wdata: {24'h0, d}, wstrb: 4'h1,
            wvalid: 1'b1, bready: 1'b1, default: '0};
        for (int c = 0; c < 100; c++) begin
            @(posedge clk_in);
            if (axi_rsp_out.awready) axi_req_in.awvalid <= 1'b0;
            if (axi_rsp_out.wready) axi_req_in.wvalid <= 1'b0;
            if (axi_rsp_out.bvalid) begin
                axi_req_in.bready <= 1'b0;
                return;
            end
        end
        stuck();
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge clk_in);
        axi_req_in <= '{araddr: a, arvalid: 1'b1, rready: 1'b1, default: '0};
        for (int c = 0; c < 100; c++) begin
            @(posedge clk_in);
            if (axi_rsp_out.arready) axi_req_in.arvalid <= 1'b0;
            if (axi_rsp_out.rvalid) begin
                rd = axi_rsp_out.rdata;
                rr = axi_rsp_out.rresp;
                axi_req_in.rready <= 1'b0;
                return;
            end
        end
        stuck();
    endtask : rdr
    task automatic send_key(input logic [63:0] k);
        @(posedge clk_in);
        dbg_key <= k;
        dbg_go <= 1'b1;
        @(posedge clk_in);
        dbg_go <= 1'b0;
        for (int c = 0; c < 20 && dbg_busy; c++) @(posedge clk_in);
        if (dbg_busy) stuck();
    endtask : send_key
    task automatic rst_pulse;
        wr(8'h20, dkua_pkg::RESET_SIG);
        `CHK(sys_reset_out, 1'b1)
        wr(8'h20, dkua_pkg::RESET_RELEASE);
        `CHK(sys_reset_out, 1'b0)
    endtask : rst_pulse
    initial begin
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        `CHK(keep_clock_out, 1'b1)
        rdr(8'h28);
        `CHK(rd[7:0], 8'h01)
        rdr(8'h3c);
        `CHK(rr, dkua_pkg::RESP_SLVERR)
        for (int i = 0; i < 4; i++) begin
            link_enable_in <= 1'b0;
            @(posedge clk_in);
            link_enable_in <= 1'b1;
            send_key(KEY_ROWS[i][71:8]);
            rdr(8'h1c);
            `CHK(rd[7:0], KEY_ROWS[i][7:0])
        end
        send_key(dkua_pkg::KEY_SIG_PROG);
        send_key(dkua_pkg::KEY_SIG_ERASE);
        rdr(8'h1c);
        `CHK(rd[7:0], 8'h18)
        rst_pulse();
        lock_bits_in <= 1'b0;
        rdr(8'h2c);
        `CHK(rd[0], 1'b1)
        `CHK(bod_level_out, 3'h5)
        `CHK(bus_grant_out, 1'b0)
        erase_done_in <= 1'b1;
        @(posedge clk_in);
        erase_done_in <= 1'b0;
        rdr(8'h2c);
        `CHK(rd[0], 1'b0)
        `CHK(bus_grant_out, 1'b1)
        rst_pulse();
        rdr(8'h2c);
        `CHK(rd[3], 1'b1)
        `CHK(prog_enabled_out, 1'b1)
        sleep_mode_in <= 2'h3;
        cpu_clock_stopped_in <= 1'b1;
        sync_rise_in <= 1'b1;
        @(posedge clk_in);
        sync_rise_in <= 1'b0;
        @(posedge clk_in);
        `CHK(sync_event_out, 1'b1)
        rdr(8'h2c);
        `CHK(rd[4], 1'b1)
        `CHK(bus_grant_out, 1'b1)
        `CHK(phy_clock_on_out, 1'b1)
        wr(8'h28, 8'h00);
        rdr(8'h2c);
        `CHK(bus_grant_out, 1'b0)
        wr(8'h28, 8'h01);
        sleep_mode_in <= 2'h0;
        cpu_clock_stopped_in <= 1'b0;
        rst_pulse();
        `CHK(prog_enabled_out, 1'b0)
        link_enable_in <= 1'b0;
        lock_bits_in <= 1'b1;
        @(posedge clk_in);
        link_enable_in <= 1'b1;
        send_key(dkua_pkg::KEY_SIG_UROW);
        rst_pulse();
        rdr(8'h2c);
        `CHK(rd[2], 1'b1)
        `CHK(sram_read_ok_out, 1'b0)
        for (int a = 0; a < 34; a++) begin
            @(posedge clk_in);
            mem_wr_in <= '{1'b1, 16'(a), 8'(a) ^ 8'ha5};
        end
        @(posedge clk_in);
        mem_wr_in.valid <= 1'b0;
        wr(8'h28, 8'h03);
        n = 0;
        for (int c = 0; c < 300 && n < 32; c++) begin
            @(posedge clk_in);
            if (row_valid_out && row_ready_in) begin
                `CHK(row_addr_out, 5'(n))
                `CHK(row_data_out, 8'(n) ^ 8'ha5)
                n++;
            end
            row_ready_in <= ~row_ready_in;
        end
        if (n < 32) stuck();
        rdr(8'h2c);
        `CHK(rd[2], 1'b0)
        wr(8'h1c, 8'h20);
        rdr(8'h1c);
        `CHK(rd[5], 1'b0)
        rst_pulse();
        test_done();
    end
endmodule : debug_key_unlock_access_bench
`default_nettype wire
